// file: core/test_channel_io_control.sv
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "tcio_defs.svh"
module test_channel_io_control (
  input  wire logic          clk_sys,
  input  wire logic          arst_n,
  input  wire logic          clk_en,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          seq_running,
  input  wire logic          vec_tick,
  input  wire logic          step_is_output,
  input  wire logic          step_is_input,
  input  wire logic          vec_bit,
  input  wire logic          phase_assert,
  input  wire logic          phase_return,
  input  wire logic          over_current,
  input  wire logic          sense_high,
  input  wire logic          sense_low,
  input  wire logic          above_clamp_hi,
  input  wire logic          below_clamp_lo,
  output logic               drv_data,
  output logic               drv_oe_n,
  output logic               rec_we,
  output logic               rec_bit,
  output logic               rec_invalid,
  output logic               load_src_en,
  output logic               load_snk_en,
  output logic      [15:0]   drive_high_level,
  output logic      [15:0]   drive_low_level,
  output logic      [15:0]   thr_high,
  output logic      [15:0]   thr_low,
  output logic      [7:0]    slew_rise,
  output logic      [7:0]    slew_fall,
  output logic      [15:0]   load_src_cur,
  output logic      [15:0]   load_snk_cur,
  output logic      [15:0]   clamp_high,
  output logic      [15:0]   clamp_low,
  output tcio_pkg::rload_t   pull_up_sel,
  output tcio_pkg::rload_t   pull_down_sel,
  output logic      [8:0]    global_chan,
  output logic               irq
);
  import tcio_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // {level, invalid} from the dual comparator
  function automatic logic [1:0] classify(input logic hi, input logic lo);
    logic lvl;
    logic inv;
    lvl = hi;
    inv = ~hi & ~lo;
    return {lvl, inv};
  endfunction

  fmt_t              fmt_r;
  logic              err_mode_r;
  logic              load_en_r;
  logic [`STAT_W-1:0] status_r;
  logic [`STAT_W-1:0] status_nxt;
  logic [`STAT_W-1:0] mask_r;
  logic [3:0]        board_r;
  logic [4:0]        chan_r;
  logic [2:0]        cap_r;
  logic              oe_gate_r;
  logic              shp_level;
  logic              shp_drive;
  logic              acc;
  logic              wr_go;
  logic              rd_go;
  logic              hit;
  logic [31:0]       rd_word;
  logic [1:0]        cls;
  logic              cap_go;
  logic              cap_bit;
  logic              set_oc;
  logic              set_inv;
  logic              clr_stat;

  // ****************************************************************
  // apb slave, one wait state
  // ****************************************************************
  assign acc   = psel & penable;
  assign wr_go = acc & pready & pwrite;
  assign rd_go = acc & pready & ~pwrite;

  // read mux and decode of mapped offsets
  always_comb begin
    rd_word = `RST_WORD;
    hit     = 1'b1;
    case (paddr)
      `OFF_CTRL:     rd_word = {26'h0, load_en_r, err_mode_r, 1'b0, fmt_r};
      `OFF_STATUS:   rd_word = {30'h0, status_r};
      `OFF_MASK:     rd_word = {30'h0, mask_r};
      `OFF_DRV_LVL:  rd_word = {drive_high_level, drive_low_level};
      `OFF_THRESH:   rd_word = {thr_high, thr_low};
      `OFF_SLEW:     rd_word = {16'h0, slew_fall, slew_rise};
      `OFF_LOAD_CUR: rd_word = {load_src_cur, load_snk_cur};
      `OFF_CLAMP:    rd_word = {clamp_high, clamp_low};
      `OFF_RLOAD:    rd_word = {28'h0, pull_down_sel, pull_up_sel};
      `OFF_CHAN_ID:  rd_word = {7'h0, global_chan, 7'h0, board_r, chan_r};
      `OFF_CAPTURE:  rd_word = {29'h0, cap_r};
      default:       hit = 1'b0;
    endcase
  end

  // answer one cycle after the access phase starts
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      prdata  <= `RST_WORD;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (acc && !pready) begin
        pready  <= 1'b1;
        prdata  <= pwrite ? `RST_WORD : rd_word;
        pslverr <= ~hit;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // analog settings accept writes regardless of seq_running
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fmt_r            <= FMT_NO_RETURN;
      err_mode_r       <= 1'b0;
      load_en_r        <= 1'b0;
      mask_r           <= `RST_STATUS;
      drive_high_level <= `RST_HALF;
      drive_low_level  <= `RST_HALF;
      thr_high         <= `RST_HALF;
      thr_low          <= `RST_HALF;
      slew_rise        <= `RST_SLEW;
      slew_fall        <= `RST_SLEW;
      load_src_cur     <= `RST_HALF;
      load_snk_cur     <= `RST_HALF;
      clamp_high       <= `RST_HALF;
      clamp_low        <= `RST_HALF;
      pull_up_sel      <= RLOAD_OPEN;
      pull_down_sel    <= RLOAD_OPEN;
      board_r          <= 4'h0;
      chan_r           <= 5'h00;
    end else if (clk_en && wr_go) begin
      case (paddr)
        `OFF_CTRL: begin
          fmt_r      <= fmt_t'(pwdata[`CTRL_FMT_MSB:`CTRL_FMT_LSB]);
          err_mode_r <= pwdata[`CTRL_RMODE];
          load_en_r  <= pwdata[`CTRL_LOADEN];
        end
        `OFF_MASK:     mask_r <= pwdata[`STAT_W-1:0];
        `OFF_DRV_LVL: begin
          drive_high_level <= pwdata[`HALF_HI_MSB:`HALF_HI_LSB];
          drive_low_level  <= pwdata[`HALF_LO_MSB:`HALF_LO_LSB];
        end
        `OFF_THRESH: begin
          thr_high <= pwdata[`HALF_HI_MSB:`HALF_HI_LSB];
          thr_low  <= pwdata[`HALF_LO_MSB:`HALF_LO_LSB];
        end
        `OFF_SLEW: begin
          slew_rise <= pwdata[`SLEW_RISE_MSB:`SLEW_RISE_LSB];
          slew_fall <= pwdata[`SLEW_FALL_MSB:`SLEW_FALL_LSB];
        end
        `OFF_LOAD_CUR: begin
          load_src_cur <= pwdata[`HALF_HI_MSB:`HALF_HI_LSB];
          load_snk_cur <= pwdata[`HALF_LO_MSB:`HALF_LO_LSB];
        end
        `OFF_CLAMP: begin
          clamp_high <= pwdata[`HALF_HI_MSB:`HALF_HI_LSB];
          clamp_low  <= pwdata[`HALF_LO_MSB:`HALF_LO_LSB];
        end
        `OFF_RLOAD: begin
          pull_up_sel   <= rload_t'(pwdata[`RL_UP_MSB:`RL_UP_LSB]);
          pull_down_sel <= rload_t'(pwdata[`RL_DN_MSB:`RL_DN_LSB]);
        end
        `OFF_CHAN_ID: begin
          board_r <= pwdata[`CID_BRD_MSB:`CID_BRD_LSB];
          chan_r  <= pwdata[`CID_CH_MSB:`CID_CH_LSB];
        end
        default: begin
          fmt_r <= fmt_r;
        end
      endcase
    end
  end

  // position of this channel in a domain of up to 16 x 32
  assign global_chan = {board_r, chan_r};

  // ****************************************************************
  // status, sticky events and interrupt
  // ****************************************************************
  assign set_oc   = over_current;
  assign set_inv  = cap_go & cls[0];
  assign clr_stat = rd_go && (paddr == `OFF_STATUS);

  // read clears, a new event in the same cycle wins
  always_comb begin
    status_nxt = clr_stat ? `RST_STATUS : status_r;
    status_nxt[`STAT_OC]  = status_nxt[`STAT_OC] | set_oc;
    status_nxt[`STAT_INV] = status_nxt[`STAT_INV] | set_inv;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= `RST_STATUS;
    end else if (clk_en) begin
      status_r <= status_nxt;
    end
  end

  assign irq = |(status_r & mask_r);

  // ****************************************************************
  // output path
  // ****************************************************************
  fmt_shaper u_shaper (
    .clk_sys      (clk_sys),
    .arst_n       (arst_n),
    .clk_en       (clk_en),
    .fmt          (fmt_r),
    .vec_tick     (vec_tick),
    .phase_assert (phase_assert),
    .phase_return (phase_return),
    .data         (vec_bit),
    .level        (shp_level),
    .drive        (shp_drive)
  );

  // driver gated by output vector and by the held fault
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      oe_gate_r <= 1'b0;
    end else if (clk_en) begin
      oe_gate_r <= step_is_output & ~status_nxt[`STAT_OC];
    end
  end

  assign drv_data = shp_level;
  assign drv_oe_n = ~(oe_gate_r & shp_drive);

  // ****************************************************************
  // input capture
  // ****************************************************************
  assign cls    = classify(sense_high, sense_low);
  assign cap_go = vec_tick & seq_running & (step_is_input | step_is_output);
  // error mode marks mismatch on input steps, response mode the level
  assign cap_bit = err_mode_r ? (step_is_input & (cls[0] | (cls[1] != vec_bit)))
                              : cls[1];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rec_we      <= 1'b0;
      rec_bit     <= 1'b0;
      rec_invalid <= 1'b0;
      cap_r       <= 3'h0;
    end else if (clk_en) begin
      rec_we <= cap_go;
      if (cap_go) begin
        rec_bit     <= cap_bit;
        rec_invalid <= cls[0];
        cap_r       <= {cap_bit, cls[0], cls[1]};
      end
    end
  end

  // constant-current load follows the clamp comparators
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      load_src_en <= 1'b0;
      load_snk_en <= 1'b0;
    end else if (clk_en) begin
      load_src_en <= load_en_r & above_clamp_hi;
      load_snk_en <= load_en_r & below_clamp_lo;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n || !clk_en);

  sequence s_lvl_write;
    wr_go && (paddr == `OFF_DRV_LVL);
  endsequence

  a_drive_only_out: assert property (!drv_oe_n |-> $past(step_is_output))
    else $error("driver enabled on a non-output vector");
  a_oc_to_hiz: assert property (over_current |=> drv_oe_n)
    else $error("driver still on after over-current");
  a_oc_flag_hold: assert property ((status_r[`STAT_OC] && !clr_stat) |=> status_r[`STAT_OC])
    else $error("over-current flag dropped without clear");
  a_oc_read_clear: assert property ((clr_stat && !over_current) |=> !status_r[`STAT_OC])
    else $error("status read did not clear over-current");
  a_cap_high: assert property ((cap_go && sense_high && !err_mode_r) |=>
      (rec_we && rec_bit && !rec_invalid))
    else $error("high input not logged as high valid");
  a_cap_low: assert property ((cap_go && sense_low && !sense_high && !err_mode_r) |=>
      (rec_we && !rec_bit && !rec_invalid))
    else $error("low input not logged as low valid");
  a_cap_mid: assert property ((cap_go && !sense_low && !sense_high) |=>
      (rec_we && rec_invalid && (err_mode_r || !rec_bit)))
    else $error("mid input not logged as invalid");
  a_cap_cause: assert property (rec_we |-> $past(vec_tick && seq_running))
    else $error("capture write without vector tick");
  a_cap_out_step: assert property ((vec_tick && seq_running && step_is_output) |=> rec_we)
    else $error("output step not captured");
  a_lvl_anytime: assert property (s_lvl_write |=>
      (drive_high_level == $past(pwdata[`HALF_HI_MSB:`HALF_HI_LSB])))
    else $error("level write lost");
  a_load_src: assert property ((load_en_r && above_clamp_hi) |=> load_src_en)
    else $error("current source not enabled above clamp");

endmodule

// file: core/tcio_defs.svh
`ifndef TCIO_DEFS_SVH
`define TCIO_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFF_CTRL      12'h000
`define OFF_STATUS    12'h004
`define OFF_MASK      12'h008
`define OFF_DRV_LVL   12'h00c
`define OFF_THRESH    12'h010
`define OFF_SLEW      12'h014
`define OFF_LOAD_CUR  12'h018
`define OFF_CLAMP     12'h01c
`define OFF_RLOAD     12'h020
`define OFF_CHAN_ID   12'h024
`define OFF_CAPTURE   12'h028

// ****************************************************************
// field positions
// ****************************************************************
`define CTRL_FMT_MSB  2
`define CTRL_FMT_LSB  0
`define CTRL_RMODE    4
`define CTRL_LOADEN   5
`define STAT_OC       0
`define STAT_INV      1
`define STAT_W        2
`define HALF_HI_MSB   31
`define HALF_HI_LSB   16
`define HALF_LO_MSB   15
`define HALF_LO_LSB   0
`define SLEW_FALL_MSB 15
`define SLEW_FALL_LSB 8
`define SLEW_RISE_MSB 7
`define SLEW_RISE_LSB 0
`define RL_DN_MSB     3
`define RL_DN_LSB     2
`define RL_UP_MSB     1
`define RL_UP_LSB     0
`define CID_BRD_MSB   8
`define CID_BRD_LSB   5
`define CID_CH_MSB    4
`define CID_CH_LSB    0
`define CID_GLB_MSB   24
`define CID_GLB_LSB   16
`define CAP_LVL       0
`define CAP_INV       1
`define CAP_ERR       2

// ****************************************************************
// reset values and domain size
// ****************************************************************
`define RST_WORD      32'h0000_0000
`define RST_STATUS    2'h0
`define RST_HALF      16'h0000
`define RST_SLEW      8'h00
`define BOARDS_MAX    16
`define CH_PER_BOARD  32
`define CH_MAX        512
`define CH_SHIFT      5

`endif

// file: core/tcio_pkg.sv
package tcio_pkg;

  // output waveform formats, encoded in the control register
  typedef enum logic [2:0] {
    FMT_NO_RETURN,
    FMT_RETURN_ZERO,
    FMT_RETURN_ONE,
    FMT_RETURN_HIZ,
    FMT_MID_BIT_INVERTING,
    FMT_SURROUND_COMPLEMENT
  } fmt_t;

  // position inside one vector period
  typedef enum logic [1:0] {
    SEG_LEAD,
    SEG_MID,
    SEG_TAIL
  } seg_t;

  // resistive load selections
  typedef enum logic [1:0] {
    RLOAD_OPEN,
    RLOAD_250,
    RLOAD_290,
    RLOAD_1K
  } rload_t;

endpackage

// file: core/fmt_shaper.sv
`timescale 1ns/1ns
module fmt_shaper (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic         clk_en,
  input  wire tcio_pkg::fmt_t fmt,
  input  wire logic         vec_tick,
  input  wire logic         phase_assert,
  input  wire logic         phase_return,
  input  wire logic         data,
  output logic              level,
  output logic              drive
);
  import tcio_pkg::*;

  seg_t seg_r;
  seg_t seg_nxt;
  logic data_r;
  logic data_nxt;
  logic level_nxt;
  logic drive_nxt;

  // ****************************************************************
  // segment tracking
  // ****************************************************************
  // a new vector restarts the period, return wins over assert
  always_comb begin
    seg_nxt  = seg_r;
    data_nxt = data_r;
    if (vec_tick) begin
      seg_nxt  = SEG_LEAD;
      data_nxt = data;
    end else if (phase_return) begin
      seg_nxt = SEG_TAIL;
    end else if (phase_assert) begin
      seg_nxt = SEG_MID;
    end
  end

  // waveform per format
  always_comb begin
    level_nxt = data_nxt;
    drive_nxt = 1'b1;
    case (fmt)
      FMT_NO_RETURN: begin
        level_nxt = data_nxt;
      end
      FMT_RETURN_ZERO: begin
        if (seg_nxt == SEG_TAIL) level_nxt = 1'b0;
      end
      FMT_RETURN_ONE: begin
        if (seg_nxt == SEG_TAIL) level_nxt = 1'b1;
      end
      FMT_RETURN_HIZ: begin
        if (seg_nxt == SEG_TAIL) drive_nxt = 1'b0;
      end
      FMT_MID_BIT_INVERTING: begin
        if (seg_nxt == SEG_TAIL) level_nxt = ~data_nxt;
      end
      FMT_SURROUND_COMPLEMENT: begin
        drive_nxt = (seg_nxt == SEG_MID);
      end
      default: begin
        level_nxt = data_nxt;
      end
    endcase
  end

  // state and registered pin levels
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      seg_r  <= SEG_LEAD;
      data_r <= 1'b0;
      level  <= 1'b0;
      drive  <= 1'b0;
    end else if (clk_en) begin
      seg_r  <= seg_nxt;
      data_r <= data_nxt;
      level  <= level_nxt;
      drive  <= drive_nxt;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_rz_return_low: assert property (@(posedge clk_sys) disable iff (!arst_n || !clk_en)
    (fmt == FMT_RETURN_ZERO && phase_return && !vec_tick) |=> (level == 1'b0))
    else $error("return to zero did not go low at return edge");

  a_surround_lead: assert property (@(posedge clk_sys) disable iff (!arst_n || !clk_en)
    (fmt == FMT_SURROUND_COMPLEMENT && vec_tick) |=> !drive)
    else $error("surround format drives before assert edge");

endmodule

// file: bench/uut_pins.sv
`timescale 1ns/1ns
// ****************************************************************
// far side pin model
// ****************************************************************
module uut_pins (
  input  wire logic       drv_data,
  input  wire logic       drv_oe_n,
  input  wire logic [1:0] uut_lvl,
  input  wire logic       fault,
  output logic            sense_high,
  output logic            sense_low,
  output logic            above_clamp_hi,
  output logic            below_clamp_lo,
  output logic            over_current
);
  logic [1:0] pin;

  // pin shows our driver while it is on, else the far side (0 low, 1 mid, 2 high)
  assign pin = drv_oe_n ? uut_lvl : {drv_data, 1'b0};
  // thresholds sit inside the clamps, high threshold above low
  assign sense_high     = (pin == 2'h2);
  assign sense_low      = (pin == 2'h0);
  assign above_clamp_hi = (pin == 2'h2);
  assign below_clamp_lo = (pin == 2'h0);
  // a short only draws current while the driver is on
  assign over_current   = fault & ~drv_oe_n;
endmodule

// file: bench/test_channel_io_control_bench.sv
`timescale 1ns/1ns
`include "tcio_defs.svh"
module test_channel_io_control_bench;
  import tcio_pkg::*;
  logic        clk_sys, arst_n, clk_en, psel, penable, pwrite, pready, pslverr, e, fault;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        seq_running, vec_tick, step_is_output, step_is_input, vec_bit;
  logic        phase_assert, phase_return, over_current, sense_high, sense_low;
  logic        above_clamp_hi, below_clamp_lo, drv_data, drv_oe_n, rec_we, rec_bit;
  logic        rec_invalid, load_src_en, load_snk_en, irq;
  logic [15:0] drive_high_level, drive_low_level, thr_high, thr_low;
  logic [15:0] load_src_cur, load_snk_cur, clamp_high, clamp_low;
  logic [7:0]  slew_rise, slew_fall;
  logic [8:0]  global_chan;
  logic [1:0]  uut_lvl;
  rload_t      pull_up_sel, pull_down_sel;
  int          err_count, comparisons;
  logic [11:0] offs [6] = '{`OFF_DRV_LVL, `OFF_THRESH, `OFF_SLEW, `OFF_LOAD_CUR,
                            `OFF_CLAMP, `OFF_RLOAD};
  logic [31:0] vals [6] = '{32'h8000_1000, 32'h6000_2000, 32'h0000_a55a,
                            32'h1234_4321, 32'h7000_1000, 32'h0000_0009};

  test_channel_io_control test_channel_io_control_inst (.*);
  uut_pins                uut_pins_inst (.*);

  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // helper tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one apb transfer, entered and left at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(pready, 1'b1);
    if (pready !== 1'b1) conclude();
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask

  // one vector tick with a far side level, then the record outputs
  task automatic cap(input logic [1:0] l, input logic w, input logic b, input logic v);
    uut_lvl  <= l;
    vec_tick <= 1'b1;
    @(posedge clk_sys);
    vec_tick <= 1'b0;
    @(posedge clk_sys);
    chk(rec_we, w);
    chk(rec_bit, b);
    chk(rec_invalid, v);
    @(posedge clk_sys);
    chk(rec_we, 1'b0);
  endtask

  // a full output vector: tick, assert edge, return edge, settle
  task automatic vec(input logic b);
    vec_bit      <= b;
    vec_tick     <= 1'b1;
    @(posedge clk_sys);
    vec_tick     <= 1'b0;
    phase_assert <= 1'b1;
    @(posedge clk_sys);
    phase_assert <= 1'b0;
    phase_return <= 1'b1;
    @(posedge clk_sys);
    phase_return <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {psel, penable, pwrite, seq_running, vec_tick, step_is_output} = '0;
    {step_is_input, vec_bit, phase_assert, phase_return, fault, arst_n} = '0;
    paddr = '0;
    pwdata = '0;
    uut_lvl = 2'h1;
    clk_en = 1'b1;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(posedge clk_sys);
    chk(drv_oe_n, 1'b1);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    // analog settings while the sequencer runs
    seq_running <= 1'b1;
    foreach (offs[i]) begin
      rd(offs[i], `RST_WORD);
      apb(1'b1, offs[i], vals[i]);
      rd(offs[i], vals[i]);
    end
    chk({drive_high_level, drive_low_level}, vals[0]);
    chk({thr_high, thr_low}, vals[1]);
    chk({slew_fall, slew_rise}, vals[2]);
    chk({load_src_cur, load_snk_cur}, vals[3]);
    chk({clamp_high, clamp_low}, vals[4]);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `OFF_RLOAD, 32'(c * 4 + 3 - c));
      chk(pull_down_sel, c);
      chk(pull_up_sel, 3 - c);
    end
    rd(12'h0fc, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, `OFF_CHAN_ID, 32'h0000_01ff);
    chk(global_chan, `CH_MAX - 1);
    rd(`OFF_CHAN_ID, 32'h01ff_01ff);
    // input classification and the invalid interrupt
    apb(1'b1, `OFF_MASK, 32'h3);
    rd(`OFF_MASK, 32'h3);
    step_is_input <= 1'b1;
    cap(2'h2, 1'b1, 1'b1, 1'b0);
    cap(2'h0, 1'b1, 1'b0, 1'b0);
    cap(2'h1, 1'b1, 1'b0, 1'b1);
    chk(irq, 1'b1);
    rd(`OFF_STATUS, 32'h2);
    rd(`OFF_STATUS, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, `OFF_MASK, 32'h0);
    cap(2'h1, 1'b1, 1'b0, 1'b1);
    chk(irq, 1'b0);
    rd(`OFF_STATUS, 32'h2);
    seq_running <= 1'b0;
    cap(2'h2, 1'b0, 1'b0, 1'b1);
    seq_running <= 1'b1;
    step_is_input <= 1'b0;
    cap(2'h2, 1'b0, 1'b0, 1'b1);
    // error record mode
    step_is_input <= 1'b1;
    apb(1'b1, `OFF_CTRL, 32'h10);
    vec_bit <= 1'b1;
    cap(2'h0, 1'b1, 1'b1, 1'b0);
    cap(2'h2, 1'b1, 1'b0, 1'b0);
    rd(`OFF_CAPTURE, 32'h1);
    rd(`OFF_CTRL, 32'h10);
    // output formats, each with both data values
    step_is_input <= 1'b0;
    step_is_output <= 1'b1;
    apb(1'b1, `OFF_MASK, 32'h1);
    for (int f = 0; f < 6; f++) begin
      for (int b = 0; b < 2; b++) begin
        logic x;
        logic z;
        z = (f == 3 || f == 5);
        x = (f == 1) ? 1'b0 : (f == 2) ? 1'b1 : (f == 4) ? ~b[0] : b[0];
        apb(1'b1, `OFF_CTRL, 32'(f));
        vec(b[0]);
        chk(drv_oe_n, z);
        if (!z) chk(drv_data, x);
      end
    end
    step_is_output <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(drv_oe_n, 1'b1);
    step_is_output <= 1'b1;
    apb(1'b1, `OFF_CTRL, 32'h0);
    vec(1'b1);
    chk(drv_oe_n, 1'b0);
    cap(2'h0, 1'b1, 1'b1, 1'b0);
    // over-current shutdown, hold and host clear
    fault <= 1'b1;
    @(posedge clk_sys);
    fault <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(drv_oe_n, 1'b1);
    chk(irq, 1'b1);
    repeat (5) @(posedge clk_sys);
    chk(drv_oe_n, 1'b1);
    rd(`OFF_STATUS, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(drv_oe_n, 1'b0);
    chk(irq, 1'b0);
    // constant current load against the clamps
    step_is_output <= 1'b0;
    apb(1'b1, `OFF_CTRL, 32'h20);
    for (int l = 0; l < 3; l++) begin
      uut_lvl <= 2'(l);
      repeat (3) @(posedge clk_sys);
      chk(load_src_en, l == 2);
      chk(load_snk_en, l == 0);
    end
    // clock enable low freezes the load outputs
    clk_en <= 1'b0;
    uut_lvl <= 2'h0;
    repeat (3) @(posedge clk_sys);
    chk(load_src_en, 1'b1);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(load_snk_en, 1'b1);
    conclude();
  end
endmodule
